// *** logic/fatal_pkg.sv ***
// fatal_pkg: constants and carriers for the fatal error reporter
// assumes one 200 MHz clock and word-wide host port accesses
// Summary of operation
// [RULE1] any fatal error lights all three status leds together
// [RULE2] fatal code goes into low byte of status/address port, offset 2
// [RULE3] code 0 means message packet held no information
// [RULE4] code 1 packet read parity/timeout, code 2 packet write
// [RULE5] self-test: 4 ram error, 5 checksum, octal 14 general fatal
// [RULE6] code 6 envelope address read error, code 7 envelope write
// [RULE7] host silent past online time limit gives octal code 11
// [RULE8] host sending more commands than accepted gives octal code 12
// [RULE9] failed dma transfer gives octal code 13
// [RULE10] invalid connection identifier gives octal code 16
// [RULE11] error in initialization sequence gives octal code 23
// [RULE12] octal 111 autoboot timeout, octal 121 diagnostics load failure
// [RULE13] every minimal disk subset command is accepted and executed; the code refuses one while fatal is latched or MAX_CMDS are pending
// [RULE14] diagnostic utility and maintenance commands are not supported
// [RULE15] logical block numbers map to cylinder, track and sector
// [RULE16] device handles media error correction, host sees clean media
// [RULE17] status/address read in normal operation returns status
// [RULE18] host accesses both 16-bit ports only as whole words
// [RULE19] fatal code and leds hold until a write to init/poll port
package fatal_pkg;
  // ------------------------------------------------------------------
  // port map and timing
  // ------------------------------------------------------------------
  localparam logic [1:0] OFS_INIT_POLL = 2'h0;
  localparam logic [1:0] OFS_STATUS_ADDR = 2'h2;
  localparam logic [2:0] LEDS_ALL_ON = 3'h7;
  localparam logic [2:0] LEDS_RESET = 3'h0;
  localparam logic [7:0] SA_FATAL_HI = 8'h80;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int ONLINE_LIMIT_US = 1000;
  localparam int NUM_SRC = 15;

  // ------------------------------------------------------------------
  // fatal codes, hex values of the octal figures
  // ------------------------------------------------------------------
  localparam logic [7:0] FC_NO_INFO = 8'h00;
  localparam logic [7:0] FC_PKT_RD = 8'h01;
  localparam logic [7:0] FC_PKT_WR = 8'h02;
  localparam logic [7:0] FC_RAM = 8'h04;
  localparam logic [7:0] FC_CHECKSUM = 8'h05;
  localparam logic [7:0] FC_ENV_RD = 8'h06;
  localparam logic [7:0] FC_ENV_WR = 8'h07;
  localparam logic [7:0] FC_ONLINE_TMO = 8'h09;
  localparam logic [7:0] FC_CMD_OVFL = 8'h0a;
  localparam logic [7:0] FC_DMA = 8'h0b;
  localparam logic [7:0] FC_CTL_FATAL = 8'h0c;
  localparam logic [7:0] FC_CONN_ID = 8'h0e;
  localparam logic [7:0] FC_INIT_SEQ = 8'h13;
  localparam logic [7:0] FC_AUTOBOOT = 8'h49;
  localparam logic [7:0] FC_DIAG_LOAD = 8'h51;

  // source index order, lowest index wins on a tie
  localparam int SRC_ONLINE_TMO = 7;
  localparam int SRC_CMD_OVFL = 8;
  localparam logic [NUM_SRC-1:0][7:0] FC_TABLE = {
    FC_DIAG_LOAD, FC_AUTOBOOT, FC_INIT_SEQ, FC_CONN_ID, FC_CTL_FATAL,
    FC_DMA, FC_CMD_OVFL, FC_ONLINE_TMO, FC_ENV_WR, FC_ENV_RD,
    FC_CHECKSUM, FC_RAM, FC_PKT_WR, FC_PKT_RD, FC_NO_INFO};

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_MINIMAL, CMD_DIAG_UTIL, CMD_MAINT_RW
  } cmd_class_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_acc;
    logic [1:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic valid;
    cmd_class_t cls;
  } cmd_req_t;
endpackage

// *** logic/fatal_error_reporting.sv ***
// fatal_error_reporting: fatal code latch, leds, port reads, command
// gate, block translation and media retry request
// assumes word-wide host requests synchronous to clock_in
`timescale 1ns/1ps
module fatal_error_reporting #(
  parameter int SPT = 17,
  parameter int HEADS = 4,
  parameter int LBN_W = 24,
  parameter int MAX_CMDS = 8,
  parameter int ONLINE_CYC = fatal_pkg::ONLINE_LIMIT_US * fatal_pkg::CLK_MHZ
) (
  input wire logic clock_in, // 200 MHz clock
  input wire logic rst_n_in, // sync reset, active low
  input wire fatal_pkg::host_req_t host_in, // host port request
  input wire logic [15:0] status_in, // normal port status word
  input wire logic [2:0] leds_in, // activity leds when healthy
  input wire logic [fatal_pkg::NUM_SRC-1:0] fatal_src_in, // fault pulses
  input wire logic online_start_in, // online step begins, pulse
  input wire fatal_pkg::cmd_req_t cmd_in, // command from host ring
  input wire logic cmd_done_in, // one command finished, pulse
  input wire logic lbn_valid_in, // block number strobe
  input wire logic [LBN_W-1:0] lbn_in, // logical block number
  input wire logic media_err_in, // media check failed, pulse
  output logic [2:0] led_out, // status leds
  output logic [15:0] rd_data_out, // host read data
  output logic fatal_out, // fatal latched
  output logic hard_init_out, // init/poll written, pulse
  output logic poll_out, // init/poll read while no fatal is latched, pulse
  output logic cmd_accept_out, // command taken, pulse
  output logic cmd_reject_out, // command refused, pulse
  output logic xlate_valid_out, // translation ready, pulse
  output logic [LBN_W-1:0] cyl_out, // cylinder
  output logic [7:0] head_out, // track within cylinder
  output logic [7:0] sector_out, // sector within track
  output logic retry_out // media reread request, pulse
);
  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (SPT < 1 || SPT > 255 || HEADS < 1 || HEADS > 255)
    $error("geometry out of range");
  if (MAX_CMDS < 1 || MAX_CMDS > 255 || ONLINE_CYC < 1)
    $error("command depth or timeout out of range");
  if (LBN_W < 8 || LBN_W > 32)
    $error("block number width out of range");

  typedef enum {ON_IDLE, ON_WAIT} online_t;

  // ------------------------------------------------------------------
  // host port decode
  // ------------------------------------------------------------------
  // byte accesses are dropped whole
  wire word_ok = !host_in.byte_acc; // RULE18
  wire ip_sel = host_in.addr == fatal_pkg::OFS_INIT_POLL;
  wire sa_sel = host_in.addr == fatal_pkg::OFS_STATUS_ADDR;
  wire ip_wr = host_in.wr && word_ok && ip_sel;
  wire ip_rd = host_in.rd && word_ok && ip_sel;
  wire sa_rd = host_in.rd && word_ok && sa_sel;
  wire host_touch = (host_in.rd || host_in.wr) && word_ok;

  logic fatal_r, fatal_nxt;
  logic [7:0] code_r, code_nxt;
  online_t on_state_r, on_state_nxt;
  logic [31:0] on_cnt_r, on_cnt_nxt;
  logic [7:0] pend_r, pend_nxt;

  // ------------------------------------------------------------------
  // command gate and credit count
  // ------------------------------------------------------------------
  wire cmd_min = cmd_in.valid && cmd_in.cls == fatal_pkg::CMD_MINIMAL;
  wire cmd_bad = cmd_in.valid && !cmd_min; // RULE14
  wire pend_full = pend_r == 8'(MAX_CMDS);
  wire cmd_take = cmd_min && !pend_full && !fatal_r; // RULE13
  wire cmd_ovfl = cmd_min && pend_full; // RULE8
  wire pend_dec = cmd_done_in && pend_r != 8'h00;
  assign pend_nxt = ip_wr ? 8'h00 :
                    pend_r + 8'(cmd_take) - 8'(pend_dec);

  // ------------------------------------------------------------------
  // online timer: host must touch a port before expiry
  // ------------------------------------------------------------------
  wire on_expire = on_state_r == ON_WAIT &&
                   on_cnt_r == 32'(ONLINE_CYC - 1); // RULE7
  always_comb begin
    on_state_nxt = on_state_r;
    on_cnt_nxt = on_cnt_r;
    unique case (on_state_r)
      ON_IDLE: begin
        on_cnt_nxt = 32'h0;
        if (online_start_in) begin
          on_state_nxt = ON_WAIT;
        end
      end
      ON_WAIT: begin
        on_cnt_nxt = on_cnt_r + 32'h1;
        if (host_touch || on_expire) begin
          on_state_nxt = ON_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // first-hit selection over fault sources
  // ------------------------------------------------------------------
  logic [fatal_pkg::NUM_SRC-1:0] src_all;
  logic [fatal_pkg::NUM_SRC:0] seen;
  logic [fatal_pkg::NUM_SRC:0][7:0] pick;
  always_comb begin
    src_all = fatal_src_in;
    src_all[fatal_pkg::SRC_ONLINE_TMO] = on_expire;
    src_all[fatal_pkg::SRC_CMD_OVFL] = cmd_ovfl;
  end
  assign seen[0] = 1'b0;
  assign pick[0] = 8'h00;
  for (genvar i = 0; i < fatal_pkg::NUM_SRC; i++) begin : g_src
    wire first = src_all[i] && !seen[i];
    assign seen[i+1] = seen[i] || src_all[i];
    // RULE3 RULE4 RULE5 RULE6 RULE9 RULE10 RULE11 RULE12
    assign pick[i+1] = first ? fatal_pkg::FC_TABLE[i] : pick[i];
  end
  wire any_fault = seen[fatal_pkg::NUM_SRC];

  // first fault latches, only an init/poll write clears
  assign fatal_nxt = ip_wr ? 1'b0 : (fatal_r || any_fault); // RULE19
  assign code_nxt = ip_wr ? fatal_pkg::CODE_RESET :
                    (fatal_r ? code_r :
                    (any_fault ? pick[fatal_pkg::NUM_SRC] : code_r));

  // ------------------------------------------------------------------
  // read data and leds
  // ------------------------------------------------------------------
  wire [15:0] sa_word = fatal_r ? {fatal_pkg::SA_FATAL_HI, code_r} // RULE2
                                : status_in; // RULE17
  wire [15:0] rd_nxt = sa_rd ? sa_word : 16'h0000;
  wire [2:0] led_nxt = fatal_nxt ? fatal_pkg::LEDS_ALL_ON : leds_in; // RULE1

  // ------------------------------------------------------------------
  // block translation and media retry
  // ------------------------------------------------------------------
  wire [LBN_W-1:0] trk = lbn_in / LBN_W'(SPT); // RULE15
  wire [LBN_W-1:0] sec_w = lbn_in % LBN_W'(SPT);
  wire [LBN_W-1:0] head_w = trk % LBN_W'(HEADS);
  wire [LBN_W-1:0] cyl_w = trk / LBN_W'(HEADS);

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fatal_r <= 1'b0;
      code_r <= fatal_pkg::CODE_RESET;
      on_state_r <= ON_IDLE;
      on_cnt_r <= 32'h0;
      pend_r <= 8'h00;
    end else begin
      fatal_r <= fatal_nxt;
      code_r <= code_nxt;
      on_state_r <= on_state_nxt;
      on_cnt_r <= on_cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      led_out <= fatal_pkg::LEDS_RESET;
      rd_data_out <= 16'h0000;
      fatal_out <= 1'b0;
      hard_init_out <= 1'b0;
      poll_out <= 1'b0;
      cmd_accept_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      xlate_valid_out <= 1'b0;
      retry_out <= 1'b0;
    end else begin
      led_out <= led_nxt;
      rd_data_out <= rd_nxt;
      fatal_out <= fatal_nxt;
      hard_init_out <= ip_wr;
      poll_out <= ip_rd && !fatal_r;
      cmd_accept_out <= cmd_take;
      cmd_reject_out <= cmd_bad || (cmd_min && !cmd_take);
      xlate_valid_out <= lbn_valid_in;
      retry_out <= media_err_in; // RULE16
    end
  end

  // translation result holds until the next strobe
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cyl_out <= '0;
      head_out <= 8'h00;
      sector_out <= 8'h00;
    end else if (lbn_valid_in) begin
      cyl_out <= cyl_w;
      head_out <= head_w[7:0];
      sector_out <= sec_w[7:0];
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_leds_fatal_on: assert property ( // RULE1
    fatal_out |-> led_out == 3'h7)
    else $error("leds not all on while fatal");
  a_sa_low_code: assert property ( // RULE2
    sa_rd && word_ok && fatal_r && !ip_wr |=> rd_data_out[7:0] == code_r)
    else $error("fatal code missing from low byte");
  a_no_info_code: assert property ( // RULE3
    !fatal_r && !ip_wr && fatal_src_in[0] |=> code_r == 8'h00 && fatal_r)
    else $error("empty packet code wrong");
  a_pkt_codes: assert property ( // RULE4
    !fatal_r && !ip_wr && fatal_src_in[2:0] == 3'b010 |=> code_r == 8'h01)
    else $error("packet read code wrong");
  a_selftest_code: assert property ( // RULE5
    !fatal_r && !ip_wr && src_all[9:0] == 10'h0 && fatal_src_in[10]
    |=> code_r == 8'h0c)
    else $error("self-test fatal code wrong");
  a_env_code: assert property ( // RULE6
    !fatal_r && !ip_wr && src_all[6:0] == 7'h40 |=> code_r == 8'h07)
    else $error("envelope write code wrong");
  a_online_tmo: assert property ( // RULE7
    on_expire && !fatal_r && !ip_wr && src_all[6:0] == 7'h00
    |=> fatal_r && code_r == 8'h09)
    else $error("online timeout code wrong");
  a_cmd_overflow: assert property ( // RULE8
    !fatal_r && !ip_wr && cmd_ovfl && src_all[7:0] == 8'h0
    |=> fatal_out && code_r == 8'h0a && led_out == 3'h7)
    else $error("command overflow not reported");
  a_dma_code: assert property ( // RULE9
    !fatal_r && !ip_wr && src_all[9:0] == 10'h200 |=> code_r == 8'h0b)
    else $error("dma code wrong");
  a_conn_code: assert property ( // RULE10
    !fatal_r && !ip_wr && src_all[11:0] == 12'h800 |=> code_r == 8'h0e)
    else $error("connection id code wrong");
  a_init_code: assert property ( // RULE11
    !fatal_r && !ip_wr && src_all[12:0] == 13'h1000 |=> code_r == 8'h13)
    else $error("init sequence code wrong");
  a_diag_code: assert property ( // RULE12
    !fatal_r && !ip_wr && src_all == 15'h4000 |=> code_r == 8'h51)
    else $error("diagnostics load code wrong");
  a_cmd_taken: assert property ( // RULE13
    cmd_min && !pend_full && !fatal_r |=> cmd_accept_out && !cmd_reject_out)
    else $error("minimal command not accepted");
  a_cmd_refused: assert property ( // RULE14
    cmd_bad |=> cmd_reject_out && !cmd_accept_out)
    else $error("unsupported command accepted");
  a_xlate_sector: assert property ( // RULE15
    lbn_valid_in |=> xlate_valid_out &&
    sector_out == 8'($past(lbn_in) % LBN_W'(SPT)))
    else $error("sector translation wrong");
  a_media_hidden: assert property ( // RULE16
    media_err_in && !any_fault && !fatal_r && !ip_wr
    |=> retry_out && !fatal_out)
    else $error("media error leaked to host");
  a_sa_status: assert property ( // RULE17
    sa_rd && !fatal_r |=> rd_data_out == $past(status_in))
    else $error("status not returned");
  a_fatal_holds: assert property ( // RULE19
    fatal_r && !ip_wr |=> fatal_r && $stable(code_r))
    else $error("fatal state lost before init write");
  a_pkt_wr_code: assert property ( // RULE4
    !fatal_r && !ip_wr && src_all[2:0] == 3'h4 |=> code_r == 8'h02)
    else $error("packet write code wrong");
  a_ram_code: assert property ( // RULE5
    !fatal_r && !ip_wr && src_all[3:0] == 4'h8 |=> code_r == 8'h04)
    else $error("self-test ram code wrong");
  a_checksum_code: assert property ( // RULE5
    !fatal_r && !ip_wr && src_all[4:0] == 5'h10 |=> code_r == 8'h05)
    else $error("self-test checksum code wrong");
  a_env_rd_code: assert property ( // RULE6
    !fatal_r && !ip_wr && src_all[5:0] == 6'h20 |=> code_r == 8'h06)
    else $error("envelope read code wrong");
  a_autoboot_code: assert property ( // RULE12
    !fatal_r && !ip_wr && src_all[13:0] == 14'h2000 |=> code_r == 8'h49)
    else $error("autoboot timeout code wrong");
  a_online_run: assert property ( // RULE7
    on_state_r == ON_WAIT && !host_touch && !on_expire
    |=> on_state_r == ON_WAIT && on_cnt_r == $past(on_cnt_r) + 32'h1)
    else $error("online timer not counting");
  a_online_stop: assert property ( // RULE7
    on_state_r == ON_WAIT && host_touch |=> on_state_r == ON_IDLE)
    else $error("host access did not stop online timer");
  a_online_bound: assert property ( // RULE7
    on_state_r == ON_WAIT |-> on_cnt_r < 32'(ONLINE_CYC))
    else $error("online timer ran past its limit");
  a_cmd_when_fatal: assert property ( // RULE13
    cmd_min && fatal_r |=> cmd_reject_out && !cmd_accept_out)
    else $error("command accepted while fatal");
  a_pend_bound: assert property ( // RULE8
    pend_r <= 8'(MAX_CMDS))
    else $error("pending command count past its limit");
  a_byte_ignored: assert property ( // RULE18
    host_in.byte_acc
    |=> !hard_init_out && !poll_out && rd_data_out == 16'h0000)
    else $error("byte access had a port effect");
  a_init_clears: assert property ( // RULE19
    ip_wr |=> !fatal_r && !fatal_out && code_r == 8'h00 && hard_init_out)
    else $error("init write did not clear fatal state");
  a_leds_at_fault: assert property ( // RULE1
    any_fault && !ip_wr |=> fatal_out && led_out == 3'h7)
    else $error("fault did not light all leds");
  a_xlate_head: assert property ( // RULE15
    lbn_valid_in |=> head_out ==
    8'(($past(lbn_in) / LBN_W'(SPT)) % LBN_W'(HEADS)))
    else $error("head translation wrong");
endmodule // fatal_error_reporting

// *** bench/host_port_model.sv ***
// host_port_model: host master for the two-port bus, word or byte accesses
// assumes a free-running clock_in and read data one edge after a read
`timescale 1ns/1ps
module host_port_model (
  input wire logic clock_in, // port clock
  input wire logic [15:0] rd_data_in, // read data from the block
  output fatal_pkg::host_req_t host_out // request to the block
);
  // ----------------------------------------------------------------
  // one transfer: raised after an edge, taken at the next, released
  // ----------------------------------------------------------------
  initial host_out = '0;
  task automatic xfer(input logic rd, input logic wr, input logic bt,
    input logic [1:0] a, input logic [15:0] wd, output logic [15:0] q);
    @(posedge clock_in);
    host_out <= '{rd: rd, wr: wr, byte_acc: bt, addr: a, wdata: wd};
    @(posedge clock_in);
    host_out.rd <= 1'b0;
    host_out.wr <= 1'b0;
    host_out.wdata <= ~wd; // released data no longer shows the word
    #1 q = rd_data_in;
  endtask
endmodule // host_port_model

// *** bench/test_fatal_error_reporting.sv ***
// test_fatal_error_reporting: self-checking bench for the reporter
// assumes the short online limit of 20 cycles set below
`timescale 1ns/1ps
module test_fatal_error_reporting;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  fatal_pkg::host_req_t host;
  logic [15:0] status_in = 16'h1234;
  logic [2:0] leds_in = 3'h2;
  logic [14:0] src = '0;
  logic start = 1'b0;
  fatal_pkg::cmd_req_t cmd = '0;
  logic done = 1'b0;
  logic lv = 1'b0;
  logic [23:0] lbn = '0;
  logic merr = 1'b0;
  logic [2:0] led;
  logic [15:0] rdd, q;
  logic fat, hinit, poll, acc, rej, xv, retry;
  logic [23:0] cyl;
  logic [7:0] head, sect;
  int num_errors = 0;
  int n_tests = 0;
  localparam int ONLINE_LIM = 20;
  logic [7:0] codes [15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h00, 8'h00, 8'h0b, 8'h0c, 8'h0e, 8'h13, 8'h49, 8'h51};

  always #2.5 clock_in = ~clock_in;

  fatal_error_reporting #(.ONLINE_CYC(ONLINE_LIM)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .host_in(host), .status_in(status_in),
    .leds_in(leds_in), .fatal_src_in(src), .online_start_in(start),
    .cmd_in(cmd), .cmd_done_in(done), .lbn_valid_in(lv), .lbn_in(lbn),
    .media_err_in(merr), .led_out(led), .rd_data_out(rdd),
    .fatal_out(fat), .hard_init_out(hinit), .poll_out(poll),
    .cmd_accept_out(acc), .cmd_reject_out(rej), .xlate_valid_out(xv),
    .cyl_out(cyl), .head_out(head), .sector_out(sect),
    .retry_out(retry));
  host_port_model host_m (.clock_in(clock_in), .rd_data_in(rdd),
    .host_out(host));

  // ----------------------------------------------------------------
  // compare, report and shared steps
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clock_in);
    #1;
  endtask
  task automatic clear;
    host_m.xfer(0, 1, 0, 2'h0, 16'h0001, q);
    chk("hard_init", hinit, 1);
    tick();
    chk("fatal_cleared", fat, 0);
  endtask
  task automatic pulse_src(input int i);
    @(posedge clock_in);
    src <= 15'h1 << i;
    @(posedge clock_in);
    src <= '0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_normal;
    chk("led_idle", led, 3'h2);
    host_m.xfer(1, 0, 0, 2'h2, 16'h0, q);
    chk("status_rd", q, 16'h1234);
    host_m.xfer(1, 0, 0, 2'h0, 16'h0, q);
    chk("poll", poll, 1);
    chk("ip_rd_data", q, 0);
    tick();
    chk("rd_after", rdd, 0);
  endtask
  task automatic t_codes;
    for (int i = 0; i < 15; i++) begin
      if (i == 7 || i == 8) continue;
      pulse_src(i);
      chk("fatal", fat, 1);
      chk("leds_on", led, 3'h7);
      pulse_src(i == 0 ? 1 : 0);
      host_m.xfer(0, 1, 1, 2'h0, 16'h0, q);
      host_m.xfer(1, 0, 0, 2'h2, 16'h0, q);
      chk("code", q, {8'h80, codes[i]});
      chk("code_hold", fat, 1);
      host_m.xfer(1, 0, 0, 2'h0, 16'h0, q);
      chk("poll_fatal", poll, 0);
      clear();
    end
  endtask
  task automatic t_online;
    int k;
    @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    for (k = 1; k <= 40; k++) begin
      tick();
      if (fat === 1'b1) break;
    end
    chk("online_edges", k, ONLINE_LIM);
    if (k > 40) summarize();
    host_m.xfer(1, 0, 0, 2'h2, 16'h0, q);
    chk("online_code", q, 16'h8009);
    clear();
    @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    host_m.xfer(1, 0, 0, 2'h2, 16'h0, q);
    repeat (40) tick();
    chk("online_stopped", fat, 0);
  endtask
  task automatic cmd1(input fatal_pkg::cmd_class_t c, input logic ok);
    @(posedge clock_in);
    cmd <= '{valid: 1'b1, cls: c};
    @(posedge clock_in);
    cmd <= '0;
    #1;
    chk("cmd_accept", acc, ok);
    chk("cmd_reject", rej, !ok);
  endtask
  task automatic t_cmds;
    cmd1(fatal_pkg::CMD_DIAG_UTIL, 0);
    cmd1(fatal_pkg::CMD_MAINT_RW, 0);
    repeat (8) cmd1(fatal_pkg::CMD_MINIMAL, 1);
    @(posedge clock_in);
    done <= 1'b1;
    @(posedge clock_in);
    done <= 1'b0;
    cmd1(fatal_pkg::CMD_MINIMAL, 1);
    cmd1(fatal_pkg::CMD_MINIMAL, 0);
    tick();
    host_m.xfer(1, 0, 0, 2'h2, 16'h0, q);
    chk("ovfl_code", q, 16'h800a);
    cmd1(fatal_pkg::CMD_MINIMAL, 0);
    clear();
  endtask
  task automatic t_xlate_media;
    @(posedge clock_in);
    lv <= 1'b1;
    lbn <= 24'd1000;
    @(posedge clock_in);
    lv <= 1'b0;
    lbn <= 24'd7;
    merr <= 1'b1;
    #1;
    chk("xv", xv, 1);
    chk("sector", sect, 8'd14);
    chk("head", head, 8'd2);
    chk("cyl", cyl, 24'd14);
    @(posedge clock_in);
    merr <= 1'b0;
    #1;
    chk("retry", retry, 1);
    chk("media_no_fatal", fat, 0);
    chk("sector_hold", sect, 8'd14);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    chk("rst_led", led, 0);
    chk("rst_fatal", fat, 0);
    tick();
    t_normal();
    t_codes();
    t_online();
    t_cmds();
    t_xlate_media();
    summarize();
  end
endmodule // test_fatal_error_reporting
